// ===== verilog/ptm_defines.vh
// register map, field positions, reset values and bus response codes of the pwm timer block
`ifndef PTM_DEFINES_VH
`define PTM_DEFINES_VH

// ==========================================================================
// register byte offsets
`define PTM_OFF_STATUS 12'h000
`define PTM_OFF_IRQ_REQ 12'h004
`define PTM_OFF_IRQ_MASK 12'h008
`define PTM_OFF_START 12'h00c
`define PTM_OFF_GEN_A0 12'h010
`define PTM_OFF_GEN_A1 12'h014
`define PTM_OFF_GEN_C0 12'h018
`define PTM_OFF_GEN_C1 12'h01c
`define PTM_OFF_BUF_CTRL 12'h020
`define PTM_OFF_COUNT0 12'h024

// ==========================================================================
// status register bits
`define PTM_ST_FLAG_A 0
`define PTM_ST_FLAG_B 1
`define PTM_ST_FLAG_C 2
`define PTM_ST_FLAG_D 3
`define PTM_ST_WRAP 4
`define PTM_ST_USED 5

// interrupt request / mask group bits
`define PTM_IRQ_CH0 1
`define PTM_IRQ_FIXED1 5
`define PTM_REQ_RESET 8'h00
`define PTM_MASK_RESET 8'hff

// start register bits
`define PTM_START_CH0 0
`define PTM_START_CH1 1
`define PTM_START_SEL0 2
`define PTM_START_SEL1 3
`define PTM_START_USED 4

// buffer control bits
`define PTM_BUF_C0 0
`define PTM_BUF_C1 1

// ==========================================================================
// reset values of the general registers and counter, and a count of one
`define PTM_GEN_RESET 16'hffff
`define PTM_CNT_RESET 16'h0000
`define PTM_CNT_ONE 16'h0001

// bus response codes
`define PTM_RESP_OKAY 2'b00
`define PTM_RESP_SLVERR 2'b10

`endif

// ===== verilog/ptm_counter.v
// one 16-bit up counter with run gate and match-to-period restart
`timescale 1ns/10ps
`include "ptm_defines.vh"

module ptm_counter #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire run,
    input wire [WIDTH-1:0] period,
    // state
    output reg [WIDTH-1:0] count_q,
    output wire match,
    output reg wrap_q
);

reg [WIDTH-1:0] count_d;

// equality of counter and period register
assign match = (count_q == period);

// ==========================================================================
// next count: restart after period match, hold when stopped
always @* begin
    count_d = count_q;
    if (run) begin
        if (match) begin
            count_d = {WIDTH{1'b0}};
        end else begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

// counter and all-ones roll-over pulse
always @(posedge aclk) begin
    if (!aresetn) begin
        count_q <= {WIDTH{1'b0}};
        wrap_q <= 1'b0;
    end else begin
        count_q <= count_d;
        wrap_q <= run && !match && (count_q == {WIDTH{1'b1}});
    end
end

endmodule // ptm_counter

// ===== verilog/ptm_flag.v
// one sticky status flag with read-then-write-zero clear
`timescale 1ns/10ps

module ptm_flag (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // event and software access
    input wire set,
    input wire read_seen,
    input wire write_zero,
    // state
    output reg flag_q
);

reg armed_q;

// ==========================================================================
// arm on read while set; zero write clears only when armed; set wins
always @(posedge aclk) begin
    if (!aresetn) begin
        flag_q <= 1'b0;
        armed_q <= 1'b0;
    end else begin
        if (set) begin
            flag_q <= 1'b1;
        end else if (write_zero && armed_q) begin
            flag_q <= 1'b0;
        end
        if (write_zero || set) begin
            armed_q <= 1'b0;
        end else if (read_seen && flag_q) begin
            armed_q <= 1'b1;
        end
    end
end

endmodule // ptm_flag

// ===== verilog/ptm_timer.v
// pwm timer channel 0 start control, compare-match flags and interrupt path
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ptm_defines.vh"

// What this block does
// - set flag a when counter equals general a
// - zero write clears flag only after read
// - status bits: a,b,c,d,wrap; upper unused
// - channel 0 pending flag at bit 1
// - mask bit 1: zero enables, one blocks
// - start bit 0 runs or stops counter 0
// - channel 1 start and selects kept independent
// - period register a0 not below a1 (not enforced: a0 and a1 are written independently)
// - buffer enable makes c registers next values
module ptm_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // interrupt
    output wire channel0_interrupt
);

// ==========================================================================
// registers
reg [11:0] awaddr_q;
reg aw_held_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg w_held_q;
reg [7:0] irq_req_q;
reg [7:0] irq_mask_q;
reg [3:0] start_q;
reg [WIDTH-1:0] gen_a0_q;
reg [WIDTH-1:0] gen_a1_q;
reg [WIDTH-1:0] gen_c0_q;
reg [WIDTH-1:0] gen_c1_q;
reg [1:0] buf_ctrl_q;
reg flag_b_set_q;
reg flag_c_set_q;
reg flag_d_set_q;

wire do_write;
wire do_read;
wire wr_lane0;
wire wr_lane1;
wire [7:0] status_byte;
wire [4:0] flags;
wire [WIDTH-1:0] count0;
wire [WIDTH-1:0] count1;
wire match0;
wire match1;
wire wrap0;
wire status_read;
wire status_write;
wire [31:0] rdata_d;
wire rd_hit;
wire wr_hit;
wire [WIDTH-1:0] wr_half;

// ==========================================================================
// write channel: address and data taken in either order
assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready = !w_held_q && !s_axi_bvalid;
assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
assign wr_lane0 = wstrb_q[0];
assign wr_lane1 = wstrb_q[1];
assign wr_half = wdata_q[WIDTH-1:0];

// address decode for writes
assign wr_hit = (awaddr_q == `PTM_OFF_STATUS) || (awaddr_q == `PTM_OFF_IRQ_REQ) ||
    (awaddr_q == `PTM_OFF_IRQ_MASK) || (awaddr_q == `PTM_OFF_START) ||
    (awaddr_q == `PTM_OFF_GEN_A0) || (awaddr_q == `PTM_OFF_GEN_A1) ||
    (awaddr_q == `PTM_OFF_GEN_C0) || (awaddr_q == `PTM_OFF_GEN_C1) ||
    (awaddr_q == `PTM_OFF_BUF_CTRL) || (awaddr_q == `PTM_OFF_COUNT0);

// hold address and data until both are in
always @(posedge aclk) begin
    if (!aresetn) begin
        awaddr_q <= 12'h000;
        aw_held_q <= 1'b0;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PTM_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
            aw_held_q <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
        end
        if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ==========================================================================
// read channel: one read at a time, answer one cycle after address
assign s_axi_arready = !s_axi_rvalid;
assign do_read = s_axi_arvalid && s_axi_arready;
assign status_read = do_read && ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_STATUS);
assign status_write = do_write && wr_lane0 && (awaddr_q == `PTM_OFF_STATUS);

// ==========================================================================
// counters of channel 0 and channel 1
ptm_counter #(
    .WIDTH(WIDTH)
) u_count0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(start_q[`PTM_START_CH0]),
    .period(gen_a0_q),
    .count_q(count0),
    .match(match0),
    .wrap_q(wrap0)
);

ptm_counter #(
    .WIDTH(WIDTH)
) u_count1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(start_q[`PTM_START_CH1]),
    .period(gen_a0_q),
    .count_q(count1),
    .match(match1),
    .wrap_q()
);

// ==========================================================================
// compare events for b, c, d flags (change points and buffers)
always @(posedge aclk) begin
    if (!aresetn) begin
        flag_b_set_q <= 1'b0;
        flag_c_set_q <= 1'b0;
        flag_d_set_q <= 1'b0;
    end else begin
        flag_b_set_q <= start_q[`PTM_START_CH0] && (count0 == gen_a1_q);
        flag_c_set_q <= start_q[`PTM_START_CH0] && buf_ctrl_q[`PTM_BUF_C0] && match0;
        flag_d_set_q <= start_q[`PTM_START_CH1] && match1;
    end
end

// ==========================================================================
// sticky status flags with read-then-zero clear
genvar fi;
generate
    for (fi = 0; fi < `PTM_ST_USED; fi = fi + 1) begin : g_flag
        wire set_ev;
        assign set_ev = (fi == `PTM_ST_FLAG_A) ? (start_q[`PTM_START_CH0] && match0) :
            (fi == `PTM_ST_FLAG_B) ? flag_b_set_q :
            (fi == `PTM_ST_FLAG_C) ? flag_c_set_q :
            (fi == `PTM_ST_FLAG_D) ? flag_d_set_q : wrap0;
        ptm_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(set_ev),
            .read_seen(status_read),
            .write_zero(status_write && !wdata_q[fi]),
            .flag_q(flags[fi])
        );
    end
endgenerate

// status byte with unused upper bits reading zero
assign status_byte = {3'b000, flags};

// ==========================================================================
// interrupt request and mask groups, start and general registers
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_req_q <= `PTM_REQ_RESET;
        irq_mask_q <= `PTM_MASK_RESET;
        start_q <= 4'h0;
        gen_a0_q <= `PTM_GEN_RESET;
        gen_a1_q <= `PTM_GEN_RESET;
        gen_c0_q <= `PTM_GEN_RESET;
        gen_c1_q <= `PTM_GEN_RESET;
        buf_ctrl_q <= 2'b00;
    end else begin
        if (do_write && wr_lane0) begin
            case (awaddr_q)
                `PTM_OFF_IRQ_REQ: irq_req_q <= s_axi_wdata_fix(wdata_q[7:0]);
                `PTM_OFF_IRQ_MASK: irq_mask_q <= wdata_q[7:0] | (8'h01 << `PTM_IRQ_FIXED1);
                `PTM_OFF_START: start_q <= wdata_q[`PTM_START_USED-1:0];
                `PTM_OFF_BUF_CTRL: buf_ctrl_q <= wdata_q[1:0];
                default: start_q <= start_q;
            endcase
        end
        if (do_write && wr_lane0 && wr_lane1) begin
            case (awaddr_q)
                `PTM_OFF_GEN_A0: gen_a0_q <= wr_half;
                `PTM_OFF_GEN_A1: gen_a1_q <= wr_half;
                `PTM_OFF_GEN_C0: gen_c0_q <= wr_half;
                `PTM_OFF_GEN_C1: gen_c1_q <= wr_half;
                default: gen_a0_q <= gen_a0_q;
            endcase
        end
        // buffered reload at period end
        if (start_q[`PTM_START_CH0] && match0) begin
            if (buf_ctrl_q[`PTM_BUF_C0]) begin
                gen_a0_q <= gen_c0_q;
            end
            if (buf_ctrl_q[`PTM_BUF_C1]) begin
                gen_a1_q <= gen_c1_q;
            end
            irq_req_q[`PTM_IRQ_CH0] <= 1'b1;
        end
    end
end

// bit five of the request group always reads zero
function [7:0] s_axi_wdata_fix;
    input [7:0] v;
    begin
        s_axi_wdata_fix = v & ~(8'h01 << `PTM_IRQ_FIXED1);
    end
endfunction

// pending and unmasked request drives the line
assign channel0_interrupt = irq_req_q[`PTM_IRQ_CH0] && !irq_mask_q[`PTM_IRQ_CH0];

// ==========================================================================
// read data mux
assign rd_hit = 1'b1;
assign rdata_d =
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_STATUS) ? {24'h000000, status_byte} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_IRQ_REQ) ? {24'h000000, irq_req_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_IRQ_MASK) ? {24'h000000, irq_mask_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_START) ? {28'h0000000, start_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_GEN_A0) ? {16'h0000, gen_a0_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_GEN_A1) ? {16'h0000, gen_a1_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_GEN_C0) ? {16'h0000, gen_c0_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_GEN_C1) ? {16'h0000, gen_c1_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_BUF_CTRL) ? {30'h00000000, buf_ctrl_q} :
    ({s_axi_araddr[11:2], 2'b00} == `PTM_OFF_COUNT0) ? {16'h0000, count0} : 32'h0000_0000;

// registered read answer, slverr for unmapped words
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PTM_RESP_OKAY;
    end else begin
        if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= (rd_hit && ({s_axi_araddr[11:2], 2'b00} <= `PTM_OFF_COUNT0)) ?
                `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // ptm_timer

// ===== tb/ptm_timer_chk.sv
// bus handshake and read answer checker of the pwm timer
`timescale 1ns/10ps
`include "ptm_defines.vh"

// ==========================================================================
// checker
module ptm_timer_chk #(
    parameter WIDTH = 16
) (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // write channels
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    // read channels
    input logic [11:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // interrupt
    input logic channel0_interrupt
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // both write halves taken on one edge
    sequence wr_both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // answers, holds and refusals
    wr_answer_a: assert property (wr_both_s |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    rd_unmapped_a: assert property (rd_take_s ##0 s_axi_araddr > 12'h027
        |=> s_axi_rresp == `PTM_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rd_mapped_a: assert property (rd_take_s ##0 s_axi_araddr <= 12'h027
        |=> s_axi_rresp == `PTM_RESP_OKAY && s_axi_rdata[31:16] == 16'h0)
        else $error("mapped read bad answer");
    st_upper_a: assert property (rd_take_s ##0 s_axi_araddr[11:2] == 10'h0
        |=> s_axi_rdata[31:5] == 27'h0)
        else $error("status unused bits set");
    irq_seen_c: cover property (channel0_interrupt);
endmodule // ptm_timer_chk

bind ptm_timer ptm_timer_chk #(.WIDTH(WIDTH)) u_ptm_timer_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .channel0_interrupt(channel0_interrupt));

// ===== tb/pwm_timer_start_and_match_irq_tb.sv
// self-checking bench of the pwm timer start and match interrupt path
`timescale 1ns/10ps
`include "ptm_defines.vh"

module pwm_timer_start_and_match_irq_tb;
    // ======================================================================
    // signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int fail_count = 0, total_checks = 0, seed = 95;
    logic [31:0] v;
    logic [1:0] resp;
    logic [15:0] a0, c0;
    logic [3:0] nib;

    // 40 mhz clock
    always #12.5 aclk = ~aclk;

    ptm_timer u_ptm_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .channel0_interrupt(irq));

    // ======================================================================
    // verdict, compare and bus tasks
    task automatic summarize;
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        fail_count++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
    endtask

    // handshakes sampled at the rising edge, each channel released right after its own
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic hb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        for (int n = 0; !hb; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                hb = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
            if (n > 50) hang();
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hd;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hd = 1'b0;
        for (int n = 0; !hd; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                hd = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
            if (n > 50) hang();
        end
    endtask

    task automatic wok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, `PTM_RESP_OKAY});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({30'h0, r}, {30'h0, `PTM_RESP_OKAY});
        chk(d & m, e);
    endtask

    task automatic wirq;
        for (int n = 0; irq !== 1'b1; n++) begin
            @(negedge aclk);
            if (n > 80) hang();
        end
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // register reset values
        rchk(`PTM_OFF_STATUS, 32'h0, 32'hffffffff);
        rchk(`PTM_OFF_IRQ_REQ, {24'h0, `PTM_REQ_RESET}, 32'hffffffff);
        rchk(`PTM_OFF_IRQ_MASK, {24'h0, `PTM_MASK_RESET}, 32'hffffffff);
        rchk(`PTM_OFF_START, 32'h0, 32'hffffffff);
        rchk(`PTM_OFF_GEN_A0, {16'h0, `PTM_GEN_RESET}, 32'hffffffff);
        rchk(`PTM_OFF_COUNT0, 32'h0, 32'hffffffff);
        // unmapped words are refused
        rd(12'h028, v, resp);
        chk({30'h0, resp}, {30'h0, `PTM_RESP_SLVERR});
        wr(12'h0fc, 32'h1, resp);
        chk({30'h0, resp}, {30'h0, `PTM_RESP_SLVERR});
        // random period, change point half of it
        repeat (4) begin
            a0 = 16'h0010 + 16'($random(seed) & 7);
            c0 = a0 + 16'h0003;
            wok(`PTM_OFF_GEN_A0, {16'h0, a0});
            wok(`PTM_OFF_GEN_A1, {16'h0, a0 >> 1});
            wok(`PTM_OFF_GEN_C0, {16'h0, c0});
            rchk(`PTM_OFF_GEN_A0, {16'h0, a0}, 32'hffffffff);
            rchk(`PTM_OFF_GEN_A1, {16'h0, a0 >> 1}, 32'hffffffff);
            rchk(`PTM_OFF_GEN_C0, {16'h0, c0}, 32'hffffffff);
        end
        // channel 1 and select bits read back as written
        repeat (4) begin
            nib = 4'($random(seed)) & 4'he;
            wok(`PTM_OFF_START, {28'h0, nib});
            rchk(`PTM_OFF_START, {28'h0, nib}, 32'hffffffff);
        end
        wok(`PTM_OFF_START, {28'h0, nib | 4'h1});
        rchk(`PTM_OFF_START, {28'h0, nib | 4'h1}, 32'hffffffff);
        wok(`PTM_OFF_START, 32'h0);
        // ordered start: flag, pending, mask, then run
        rd(`PTM_OFF_STATUS, v, resp);
        wok(`PTM_OFF_STATUS, 32'h0);
        wok(`PTM_OFF_IRQ_REQ, 32'h0);
        wok(`PTM_OFF_IRQ_MASK, 32'h0fd);
        chk({31'h0, irq}, 32'h0);
        wok(`PTM_OFF_START, 32'h1);
        wirq();
        rchk(`PTM_OFF_STATUS, 32'h1, 32'h1);
        rchk(`PTM_OFF_IRQ_REQ, 32'h2, 32'h2);
        // mask blocks the pending request
        wok(`PTM_OFF_IRQ_MASK, 32'h0ff);
        chk({31'h0, irq}, 32'h0);
        wok(`PTM_OFF_IRQ_MASK, 32'h0fd);
        chk({31'h0, irq}, 32'h1);
        // stopped counter holds its value
        wok(`PTM_OFF_START, 32'h0);
        rd(`PTM_OFF_COUNT0, v, resp);
        rchk(`PTM_OFF_COUNT0, v, 32'hffffffff);
        // fresh set after the last status read leaves the flag unarmed
        wok(`PTM_OFF_IRQ_REQ, 32'h0);
        wok(`PTM_OFF_START, 32'h1);
        wirq();
        wok(`PTM_OFF_START, 32'h0);
        // zero write without a read before it is ignored
        wok(`PTM_OFF_STATUS, 32'h0);
        rchk(`PTM_OFF_STATUS, 32'h1, 32'h1);
        wok(`PTM_OFF_STATUS, 32'h0);
        rchk(`PTM_OFF_STATUS, 32'h0, 32'h1);
        wok(`PTM_OFF_IRQ_REQ, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // buffered period reloads general a0
        wok(`PTM_OFF_BUF_CTRL, 32'h1);
        wok(`PTM_OFF_START, 32'h1);
        wirq();
        wok(`PTM_OFF_START, 32'h0);
        rchk(`PTM_OFF_GEN_A0, {16'h0, c0}, 32'hffffffff);
        summarize();
    end
endmodule // pwm_timer_start_and_match_irq_tb
